// ===== logic/sensor_fifo_trigger_readout.sv
// sensor word buffer with trigger-gated modes, tagged readout and batch counter
// assumes register access and sensor inputs synchronous to core_clk_i
//
// Contract
// - mode 100 stores continuously while trigger high, else buffer held cleared.
// - mode 111 stores until full while trigger high, else buffer held cleared.
// - trigger is single tap, double tap, wake-up, free-fall or orientation change.
// - each word is seven bytes; tag byte of current word reads at 78h.
// - six payload bytes of current word read at 79h through 7Eh.
// - ten-bit unread word count reads across 3Ah and 3Bh.
// - count batch events; reaching 11-bit threshold at 0Bh/0Ch sets batch flag.
// - one select bit at 0Bh picks accelerometer or gyroscope batch events.
// - batch flag drives interrupt pin one or two when routing bit set.
// - compression active only when enables at 05h and 08h are both one.
// - while compressing, two-bit rate field forces periodic uncompressed words.
// - logging bit at 08h inserts meta words on sensor rate changes.
// - mode 001 stores until full, then accepts no more samples.
// - continuous storing overwrites the oldest words with new ones.
// - overrun flag at 3Bh sets when an unread word was overwritten.
// - watermark flag set while unread count is at least the 9-bit level.

`timescale 1ns/1ns

module sensor_fifo_trigger_readout (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   input wire logic sample_valid_i,
   input wire sfifo_pkg::sample_t sample_i,
   output logic sample_ready_o,
   input wire logic [sfifo_pkg::NUM_TRIG-1:0] detector_events_i,
   input wire logic [3:0] acc_rate_cfg_i,
   input wire logic [3:0] gyr_rate_cfg_i,
   output logic irq_pin_one_o,
   output logic irq_pin_two_o
);
   import sfifo_pkg::*;

   // ----------------------------------------
   // decode helpers
   // ----------------------------------------
   function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
      hit = (addr == ofs);
   endfunction : hit

   // what storing the mode asks for, given the trigger level
   function automatic store_kind_t kind_of(input logic [2:0] mode, input logic trig);
      case (mode)
         MODE_STOP: kind_of = KIND_STOP;
         MODE_CONT: kind_of = KIND_OVER;
         MODE_BYP_TO_CONT: kind_of = trig ? KIND_OVER : KIND_NONE;
         MODE_BYP_TO_STOP: kind_of = trig ? KIND_STOP : KIND_NONE;
         MODE_CONT_TO_STOP: kind_of = trig ? KIND_STOP : KIND_OVER;
         default: kind_of = KIND_NONE;
      endcase
   endfunction : kind_of

   function automatic logic gated(input logic [2:0] mode);
      gated = (mode == MODE_BYP_TO_CONT) || (mode == MODE_BYP_TO_STOP);
   endfunction : gated

   // ----------------------------------------
   // state
   // ----------------------------------------
   logic [7:0] emb_q, emb_d, ctl1_q, ctl1_d, ctl2_q, ctl2_d, ctl4_q, ctl4_d;
   logic [7:0] bat1_q, bat1_d, bat2_q, bat2_d, irq_pin_one_q, irq_pin_one_d;
   logic [7:0] rdata_d;
   logic trig_q, trig_d, ovr_q, ovr_d, bflag_q, bflag_d;
   logic ready_d, irq1_d, irq2_d, meta_q, meta_d;
   logic [10:0] bcnt_q, bcnt_d;
   logic [5:0] rawcnt_q, rawcnt_d;
   logic [3:0] acfg_q, acfg_d, gcfg_q, gcfg_d;

   // buffer side
   word_t in_word, head;
   logic f_in_valid, f_in_ready, f_out_valid, f_out_ready, flush;
   logic [3:0] f_count;
   logic [9:0] unread;
   logic [10:0] thr;
   logic [8:0] wtm;
   logic [2:0] mode, trig_sel;
   logic [1:0] raw_rate;
   store_kind_t kind, kind_nxt;
   logic trig_now, fall, host_pop, sample_push, meta_push, drop_old, compress;
   logic force_raw, batch_evt, cfg_change, full, wtm_hit;
   logic [4:0] cnt_nxt;

   // ----------------------------------------
   // field views
   // ----------------------------------------
   assign mode = ctl4_q[MODE_LSB +: 3];
   assign trig_sel = ctl4_q[TRIG_SEL_LSB +: 3];
   assign thr = {bat1_q[2:0], bat2_q};
   assign wtm = {ctl2_q[WTM_HIGH_BIT], ctl1_q};
   assign raw_rate = ctl2_q[RAW_RATE_LSB +: 2];
   assign compress = emb_q[COMPR_FEAT_BIT] && ctl2_q[COMPR_RT_BIT];
   assign unread = {6'h00, f_count};
   assign full = (f_count == 4'(BUF_DEPTH));
   assign wtm_hit = ({5'h00, f_count} >= wtm);

   // ----------------------------------------
   // trigger and store mode
   // ----------------------------------------
   // an out-of-range selection gives a trigger that stays low
   assign trig_now = (trig_sel < 3'(NUM_TRIG)) && detector_events_i[trig_sel];
   assign kind = kind_of(mode, trig_q);
   assign fall = gated(mode) && trig_q && !trig_now;
   // bypass, or a gated mode with the trigger low, keeps the buffer empty
   assign flush = (kind == KIND_NONE) || fall;

   // ----------------------------------------
   // buffer write side
   // ----------------------------------------
   // samples are taken only on sample_ready_o, so a full stop-mode buffer stalls them
   assign sample_push = sample_valid_i && sample_ready_o && !flush;
   // room is judged from the count, not from the queue's ready, which waits on the overwrite
   assign meta_push = meta_q && !sample_push && !flush
      && (!full || host_pop || (kind == KIND_OVER));
   assign host_pop = reg_rd_i && hit(reg_addr_i, OFS_PAY_LAST) && f_out_valid;
   assign drop_old = (kind == KIND_OVER) && full && (sample_push || meta_push)
      && !host_pop;
   assign f_in_valid = sample_push || meta_push;
   assign f_out_ready = host_pop || drop_old;
   assign force_raw = (raw_rate != 2'h0)
      && (rawcnt_q == 6'((8 << raw_rate) - 1));
   assign batch_evt = sample_push && f_in_ready
      && (sample_i.is_gyro == bat1_q[BATCH_SEL_BIT]);
   assign cfg_change = (acc_rate_cfg_i != acfg_q) || (gyr_rate_cfg_i != gcfg_q);

   // word tagging: meta words record both rate settings in the last payload byte
   always_comb begin
      in_word.payload = sample_i.data;
      if (meta_push) begin
         in_word.tag = TAG_CFG_CHANGE;
         in_word.payload = {acfg_q, gcfg_q, 40'h00_0000_0000};
      end else if (compress && !force_raw) begin
         in_word.tag = sample_i.is_gyro ? TAG_GYR_COMP : TAG_ACC_COMP;
      end else begin
         in_word.tag = sample_i.is_gyro ? TAG_GYR_RAW : TAG_ACC_RAW;
      end
   end

   word_fifo #(
      .WIDTH($bits(word_t)),
      .DEPTH(BUF_DEPTH)
   ) u_buf (
      .core_clk_i(core_clk_i),
      .nrst_i(nrst_i),
      .flush_i(flush),
      .in_valid_i(f_in_valid),
      .in_data_i(in_word),
      .in_ready_o(f_in_ready),
      .out_valid_o(f_out_valid),
      .out_data_o(head),
      .out_ready_i(f_out_ready),
      .count_o(f_count)
   );

   // ----------------------------------------
   // register writes
   // ----------------------------------------
   always_comb begin
      emb_d = emb_q;
      ctl1_d = ctl1_q;
      ctl2_d = ctl2_q;
      ctl4_d = ctl4_q;
      bat1_d = bat1_q;
      bat2_d = bat2_q;
      irq_pin_one_d = irq_pin_one_q;
      if (reg_wr_i) begin
         if (hit(reg_addr_i, OFS_EMB_EN_B)) emb_d = reg_wdata_i;
         else if (hit(reg_addr_i, OFS_CTRL_ONE)) ctl1_d = reg_wdata_i;
         else if (hit(reg_addr_i, OFS_CTRL_TWO)) ctl2_d = reg_wdata_i;
         else if (hit(reg_addr_i, OFS_CTRL_FOUR)) ctl4_d = reg_wdata_i;
         else if (hit(reg_addr_i, OFS_BATCH_ONE)) bat1_d = reg_wdata_i;
         else if (hit(reg_addr_i, OFS_BATCH_TWO)) bat2_d = reg_wdata_i;
         else if (hit(reg_addr_i, OFS_INT_ONE)) irq_pin_one_d = reg_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         emb_q <= REG_RESET;
         ctl1_q <= REG_RESET;
         ctl2_q <= REG_RESET;
         ctl4_q <= REG_RESET;
         bat1_q <= REG_RESET;
         bat2_q <= REG_RESET;
         irq_pin_one_q <= REG_RESET;
      end else begin
         emb_q <= emb_d;
         ctl1_q <= ctl1_d;
         ctl2_q <= ctl2_d;
         ctl4_q <= ctl4_d;
         bat1_q <= bat1_d;
         bat2_q <= bat2_d;
         irq_pin_one_q <= irq_pin_one_d;
      end
   end

   // ----------------------------------------
   // flags, counters and outputs
   // ----------------------------------------
   // ready looks one cycle ahead so that the output can come from a flop
   assign cnt_nxt = flush ? 5'h00
      : 5'(f_count) + 5'(f_in_valid && f_in_ready) - 5'(f_out_ready && f_out_valid);
   assign kind_nxt = kind_of(ctl4_d[MODE_LSB +: 3], trig_now);

   always_comb begin
      trig_d = trig_now;
      acfg_d = acc_rate_cfg_i;
      gcfg_d = gyr_rate_cfg_i;
      // a change seen while a meta word waits is merged into it
      meta_d = meta_q && !meta_push;
      if (cfg_change && ctl2_q[CFG_LOG_BIT]) meta_d = 1'b1;
      if (flush) meta_d = 1'b0;
      ready_d = !meta_d && !((kind_nxt == KIND_STOP) && (cnt_nxt >= 5'(BUF_DEPTH)));
      // overrun: a flush clears it; an overwrite in the same cycle as a flush is not kept
      ovr_d = ovr_q;
      if (flush) ovr_d = 1'b0;
      if (drop_old && f_out_valid && !flush) ovr_d = 1'b1;
      // forced raw spacing counts compressed words only
      rawcnt_d = rawcnt_q;
      if (!compress || (sample_push && force_raw)) rawcnt_d = 6'h00;
      else if (sample_push) rawcnt_d = rawcnt_q + 6'h01;
      // batch counter; reading the second status byte clears the flag, a set wins
      bcnt_d = bcnt_q;
      bflag_d = bflag_q;
      if (reg_rd_i && hit(reg_addr_i, OFS_STATUS_TWO)) bflag_d = 1'b0;
      // a zero threshold disables the counter, which then waits at zero
      if (thr == 11'h000) begin
         bcnt_d = 11'h000;
      end else if (batch_evt) begin
         if (bcnt_q + 11'h001 >= thr) begin
            bcnt_d = 11'h000;
            bflag_d = 1'b1;
         end else begin
            bcnt_d = bcnt_q + 11'h001;
         end
      end
      irq1_d = bflag_d && irq_pin_one_d[IRQ_ONE_BIT];
      irq2_d = bflag_d && irq_pin_one_d[IRQ_TWO_BIT];
   end

   // register read port: answer appears the cycle after the read strobe
   always_comb begin
      rdata_d = reg_rdata_o;
      if (reg_rd_i) begin
         if (hit(reg_addr_i, OFS_EMB_EN_B)) rdata_d = emb_q;
         else if (hit(reg_addr_i, OFS_CTRL_ONE)) rdata_d = ctl1_q;
         else if (hit(reg_addr_i, OFS_CTRL_TWO)) rdata_d = ctl2_q;
         else if (hit(reg_addr_i, OFS_CTRL_FOUR)) rdata_d = ctl4_q;
         else if (hit(reg_addr_i, OFS_BATCH_ONE)) rdata_d = bat1_q;
         else if (hit(reg_addr_i, OFS_BATCH_TWO)) rdata_d = bat2_q;
         else if (hit(reg_addr_i, OFS_INT_ONE)) rdata_d = irq_pin_one_q;
         else if (hit(reg_addr_i, OFS_STATUS_ONE)) rdata_d = unread[7:0];
         else if (hit(reg_addr_i, OFS_STATUS_TWO))
            rdata_d = {wtm_hit, ovr_q, full, bflag_q, 2'h0, unread[9:8]};
         else if (hit(reg_addr_i, OFS_TAG))
            rdata_d = f_out_valid ? head.tag : 8'h00;
         else if (reg_addr_i >= OFS_PAY_FIRST && reg_addr_i <= OFS_PAY_LAST)
            rdata_d = f_out_valid ? head.payload[8*(reg_addr_i - OFS_PAY_FIRST) +: 8]
               : 8'h00;
         else rdata_d = 8'h00;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         trig_q <= 1'b0;
         acfg_q <= 4'h0;
         gcfg_q <= 4'h0;
         meta_q <= 1'b0;
         ovr_q <= 1'b0;
         rawcnt_q <= 6'h00;
         bcnt_q <= 11'h000;
         bflag_q <= 1'b0;
         sample_ready_o <= 1'b0;
         irq_pin_one_o <= 1'b0;
         irq_pin_two_o <= 1'b0;
         reg_rdata_o <= 8'h00;
      end else begin
         trig_q <= trig_d;
         acfg_q <= acfg_d;
         gcfg_q <= gcfg_d;
         meta_q <= meta_d;
         ovr_q <= ovr_d;
         rawcnt_q <= rawcnt_d;
         bcnt_q <= bcnt_d;
         bflag_q <= bflag_d;
         sample_ready_o <= ready_d;
         irq_pin_one_o <= irq1_d;
         irq_pin_two_o <= irq2_d;
         reg_rdata_o <= rdata_d;
      end
   end

   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   chk_gated_cont_clear: assert property (
      (mode == MODE_BYP_TO_CONT && !trig_q) |=> (f_count == 4'h0))
      else $error("gated continuous buffer not cleared");
   chk_gated_stop_clear: assert property (
      (mode == MODE_BYP_TO_STOP && !trig_q) |=> (f_count == 4'h0))
      else $error("gated stop buffer not cleared");
   chk_trigger_pick: assert property (
      (trig_sel == 3'h2 && detector_events_i[2]) |=> trig_q)
      else $error("selected detector event not taken as trigger");
   chk_tag_read: assert property (
      (reg_rd_i && reg_addr_i == OFS_TAG && f_out_valid) |=> (reg_rdata_o == $past(head.tag)))
      else $error("tag byte wrong");
   chk_pay_byte: assert property (
      (reg_rd_i && reg_addr_i == OFS_PAY_FIRST && f_out_valid)
      |=> (reg_rdata_o == $past(head.payload[7:0])))
      else $error("first payload byte wrong");
   chk_count_read: assert property (
      (reg_rd_i && reg_addr_i == OFS_STATUS_ONE) |=> (reg_rdata_o == $past(unread[7:0])))
      else $error("unread count low byte wrong");
   chk_stop_no_push: assert property (
      (kind == KIND_STOP && full && !host_pop) |-> !f_in_valid)
      else $error("stop mode stored into a full buffer");
   chk_overrun_set: assert property (
      (drop_old && f_out_valid && !flush) |=> ovr_q)
      else $error("overwrite did not raise overrun");
   chk_word_removed: assert property (
      (host_pop && !f_in_valid && !flush) |=> (f_count == $past(f_count) - 4'h1))
      else $error("last payload read did not remove word");
   chk_fall_flush: assert property (
      fall |=> (f_count == 4'h0 && !ovr_q) [*2])
      else $error("trigger fall did not discard buffer");
   chk_irq_route: assert property (
      ($rose(bflag_q) && irq_pin_one_q[IRQ_ONE_BIT]) |-> irq_pin_one_o)
      else $error("batch flag not routed to pin one");

endmodule : sensor_fifo_trigger_readout

// ===== logic/sfifo_pkg.sv
// constants, field layout and carrier types of the sensor word buffer
// assumes one 100 MHz core clock and byte-wide register access

package sfifo_pkg;

   // ----------------------------------------
   // register offsets
   // ----------------------------------------
   localparam logic [7:0] OFS_EMB_EN_B = 8'h05;
   localparam logic [7:0] OFS_CTRL_ONE = 8'h07;
   localparam logic [7:0] OFS_CTRL_TWO = 8'h08;
   localparam logic [7:0] OFS_CTRL_FOUR = 8'h0A;
   localparam logic [7:0] OFS_BATCH_ONE = 8'h0B;
   localparam logic [7:0] OFS_BATCH_TWO = 8'h0C;
   localparam logic [7:0] OFS_INT_ONE = 8'h0D;
   localparam logic [7:0] OFS_STATUS_ONE = 8'h3A;
   localparam logic [7:0] OFS_STATUS_TWO = 8'h3B;
   localparam logic [7:0] OFS_TAG = 8'h78;
   localparam logic [7:0] OFS_PAY_FIRST = 8'h79;
   localparam logic [7:0] OFS_PAY_LAST = 8'h7E;
   localparam logic [7:0] REG_RESET = 8'h00;

   // ----------------------------------------
   // field positions
   // ----------------------------------------
   localparam int COMPR_FEAT_BIT = 3;
   localparam int WTM_HIGH_BIT = 0;
   localparam int RAW_RATE_LSB = 1;
   localparam int CFG_LOG_BIT = 4;
   localparam int COMPR_RT_BIT = 6;
   localparam int MODE_LSB = 0;
   localparam int TRIG_SEL_LSB = 4;
   localparam int BATCH_SEL_BIT = 7;
   localparam int IRQ_ONE_BIT = 6;
   localparam int IRQ_TWO_BIT = 7;
   localparam int ST_WTM_BIT = 7;
   localparam int ST_OVR_BIT = 6;
   localparam int ST_FULL_BIT = 5;
   localparam int ST_BATCH_BIT = 4;

   // ----------------------------------------
   // buffer modes and store kinds
   // ----------------------------------------
   localparam logic [2:0] MODE_BYPASS = 3'h0;
   localparam logic [2:0] MODE_STOP = 3'h1;
   localparam logic [2:0] MODE_CONT_TO_STOP = 3'h3;
   localparam logic [2:0] MODE_BYP_TO_CONT = 3'h4;
   localparam logic [2:0] MODE_CONT = 3'h6;
   localparam logic [2:0] MODE_BYP_TO_STOP = 3'h7;
   localparam int NUM_TRIG = 5;
   typedef enum logic [1:0] {KIND_NONE, KIND_STOP, KIND_OVER} store_kind_t;

   // ----------------------------------------
   // word tags and sizes
   // ----------------------------------------
   localparam logic [7:0] TAG_GYR_RAW = 8'h08;
   localparam logic [7:0] TAG_ACC_RAW = 8'h10;
   localparam logic [7:0] TAG_GYR_COMP = 8'h38;
   localparam logic [7:0] TAG_ACC_COMP = 8'h40;
   localparam logic [7:0] TAG_CFG_CHANGE = 8'h48;
   localparam int BUF_DEPTH = 8;

   typedef struct packed {
      logic is_gyro;
      logic [47:0] data;
   } sample_t;

   typedef struct packed {
      logic [7:0] tag;
      logic [47:0] payload;
   } word_t;

endpackage : sfifo_pkg

// ===== logic/word_fifo.sv
// flop-based word queue with valid/ready on both sides and a flush
// assumes the owner drops the head itself when it wants overwrite

`timescale 1ns/1ns

module word_fifo #(
   parameter int WIDTH = 56,
   parameter int DEPTH = 8
) (
   input wire logic core_clk_i,
   input wire logic nrst_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   input wire logic [WIDTH-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   output logic [WIDTH-1:0] out_data_o,
   input wire logic out_ready_i,
   output logic [$clog2(DEPTH):0] count_o
);
   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL_CNT = (AW+1)'(DEPTH);
   localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [WIDTH-1:0] mem_d [DEPTH];
   logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
   logic [AW:0] cnt_q, cnt_d;
   logic push, pop;

   // ----------------------------------------
   // handshake and pointer update
   // ----------------------------------------
   // a pop frees a slot in the same cycle, so a full queue can still take a word
   assign in_ready_o = (cnt_q != FULL_CNT) || out_ready_i;
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o = mem_q[rd_q];
   assign count_o = cnt_q;
   assign push = in_valid_i && in_ready_o;
   assign pop = out_valid_o && out_ready_i;

   always_comb begin
      wr_d = wr_q;
      rd_d = rd_q;
      cnt_d = cnt_q;
      if (flush_i) begin
         wr_d = '0;
         rd_d = '0;
         cnt_d = '0;
      end else begin
         if (push) wr_d = (wr_q == LAST_IDX) ? '0 : wr_q + 1'b1;
         if (pop) rd_d = (rd_q == LAST_IDX) ? '0 : rd_q + 1'b1;
         cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         wr_q <= wr_d;
         rd_q <= rd_d;
         cnt_q <= cnt_d;
      end
   end

   // ----------------------------------------
   // storage slots
   // ----------------------------------------
   // contents need no reset: the count alone says what is valid
   for (genvar i = 0; i < DEPTH; i++) begin : g_slot
      always_comb begin
         mem_d[i] = mem_q[i];
         if (push && !flush_i && (wr_q == AW'(i))) mem_d[i] = in_data_i;
      end
      always_ff @(posedge core_clk_i) begin
         mem_q[i] <= mem_d[i];
      end
   end

endmodule : word_fifo

// ===== tb/host_port_model.sv
// host processor model that drives the register port of the sensor word buffer
// assumes the bench calls its tasks and that rdata settles one cycle after a read

`timescale 1ns/1ns

module host_port_model (
   input wire logic core_clk_i,
   output logic [7:0] reg_addr_o,
   output logic reg_wr_o,
   output logic reg_rd_o,
   output logic [7:0] reg_wdata_o,
   input wire logic [7:0] reg_rdata_i
);
   // ----------------------------------------
   // register access
   // ----------------------------------------
   // idle port at time zero
   initial begin
      reg_addr_o = 8'h00;
      reg_wr_o = 1'b0;
      reg_rd_o = 1'b0;
      reg_wdata_o = 8'hFF;
   end

   // write data is inverted once released, so stale data never looks fresh
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge core_clk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d;
   endtask : wr

   // strobe lasts one edge; the answer is taken at the following falling edge
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge core_clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge core_clk_i);
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
   endtask : rd

   // whole word: tag first, then all six payload bytes, low byte first
   task automatic read_word(output logic [7:0] tag, output logic [47:0] pay);
      logic [7:0] b;
      rd(8'h78, tag);
      for (int i = 0; i < 6; i++) begin
         rd(8'h79 + 8'(i), b);
         pay[8*i +: 8] = b;
      end
   endtask : read_word
endmodule : host_port_model

// ===== tb/sensor_fifo_trigger_readout_test.sv
// self-checking bench for the sensor word buffer
// assumes host_port_model on the register port; stimulus changes at falling edges

`timescale 1ns/1ns

module sensor_fifo_trigger_readout_test;
   import sfifo_pkg::*;
   logic clk, nrst, wr, rd, sv, srdy, irq1, irq2;
   logic [7:0] addr, wdata, rdata, b, t;
   logic [47:0] p;
   logic [4:0] det;
   logic [3:0] accr, gyrr;
   logic [2:0] m;
   sample_t smp;
   int n_fail, checked;

   sensor_fifo_trigger_readout dut_u (.core_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr),
      .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata),
      .sample_valid_i(sv), .sample_i(smp), .sample_ready_o(srdy), .detector_events_i(det),
      .acc_rate_cfg_i(accr), .gyr_rate_cfg_i(gyrr), .irq_pin_one_o(irq1),
      .irq_pin_two_o(irq2));
   host_port_model host_u (.core_clk_i(clk), .reg_addr_o(addr), .reg_wr_o(wr),
      .reg_rd_o(rd), .reg_wdata_o(wdata), .reg_rdata_i(rdata));

   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task automatic chk(input logic [55:0] seen, input logic [55:0] exp);
      checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : chk

   function automatic logic [47:0] dat(input int i);
      return {8'hC3, 32'h0, 8'(i)};
   endfunction : dat

   // offer one sample; gives up after four refused cycles (stop mode at full)
   task automatic push(input logic g, input logic [47:0] d);
      @(negedge clk);
      smp = '{is_gyro: g, data: d};
      sv = 1'b1;
      for (int k = 0; k < 4; k++) begin
         if (srdy === 1'b1) break;
         @(negedge clk);
      end
      @(negedge clk);
      sv = 1'b0;
      smp.data = ~d;
   endtask : push

   task automatic cnt(input logic [7:0] n);
      host_u.rd(OFS_STATUS_ONE, b);
      chk(b, n);
   endtask : cnt

   task automatic st2(input logic [7:0] e);
      host_u.rd(OFS_STATUS_TWO, b);
      chk(b, e);
   endtask : st2

   task automatic finish_test;
      $display("comparisons %0d, mismatches %0d", checked, n_fail);
      if (n_fail == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : finish_test

   // ----------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // whole run needs well under 10k cycles
   initial begin
      #500000;
      n_fail++;
      finish_test();
   end

   initial begin
      nrst = 1'b0;
      sv = 1'b0;
      smp = '0;
      det = 5'h00;
      accr = 4'h0;
      gyrr = 4'h0;
      repeat (4) @(posedge clk);
      @(negedge clk);
      nrst = 1'b1;
      host_u.rd(OFS_CTRL_FOUR, b);
      chk(b, REG_RESET);
      cnt(8'h00);
      // stop mode fills to eight then refuses
      host_u.wr(OFS_CTRL_ONE, 8'h03);
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_STOP});
      for (int i = 0; i < 10; i++) push(1'b0, dat(i));
      chk(srdy, 1'b0);
      cnt(8'h08);
      st2(8'hA0);
      host_u.read_word(t, p);
      chk(t, TAG_ACC_RAW);
      chk(p, dat(0));
      cnt(8'h07);
      // continuous mode drops the two oldest words
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_BYPASS});
      cnt(8'h00);
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_CONT});
      for (int i = 0; i < 10; i++) push(1'b0, dat(i));
      st2(8'hE0);
      host_u.read_word(t, p);
      chk(p, dat(2));
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_BYPASS});
      st2(8'h00);
      // both gated modes under every trigger source
      for (int j = 0; j < 2; j++) begin
         m = (j == 0) ? MODE_BYP_TO_CONT : MODE_BYP_TO_STOP;
         for (int s = 0; s < NUM_TRIG; s++) begin
            host_u.wr(OFS_CTRL_FOUR, {1'b0, 3'(s), 1'b0, m});
            push(1'b0, dat(s));
            cnt(8'h00);
            det = 5'(1 << s);
            repeat (2) @(negedge clk);
            for (int i = 0; i < 9; i++) push(1'b0, dat(i));
            cnt(8'h08);
            st2((j == 0) ? 8'hE0 : 8'hA0);
            det = 5'h00;
            repeat (2) @(negedge clk);
            st2(8'h00);
            cnt(8'h00);
         end
      end
      // batch counter on gyro samples, threshold three, both pins routed
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_STOP});
      host_u.wr(OFS_BATCH_ONE, 8'h80);
      host_u.wr(OFS_BATCH_TWO, 8'h03);
      host_u.wr(OFS_INT_ONE, 8'hC0);
      for (int i = 0; i < 5; i++) push(i > 2, dat(i));
      repeat (2) @(negedge clk);
      chk({irq2, irq1}, 2'b00);
      push(1'b1, dat(5));
      repeat (2) @(negedge clk);
      chk({irq2, irq1}, 2'b11);
      host_u.rd(OFS_STATUS_TWO, b);
      chk(b[ST_BATCH_BIT], 1'b1);
      repeat (2) @(negedge clk);
      chk({irq2, irq1}, 2'b00);
      // compression needs both enables
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_BYPASS});
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_STOP});
      host_u.wr(OFS_EMB_EN_B, 8'h08);
      host_u.wr(OFS_CTRL_TWO, 8'h40);
      push(1'b0, dat(5));
      host_u.wr(OFS_EMB_EN_B, 8'h00);
      push(1'b1, dat(6));
      host_u.read_word(t, p);
      chk({t, p}, {TAG_ACC_COMP, dat(5)});
      host_u.read_word(t, p);
      chk(t, TAG_GYR_RAW);
      // rate 1 forces every sixteenth word raw; mode 011 runs on until its trigger stops it
      host_u.wr(OFS_EMB_EN_B, 8'h08);
      host_u.wr(OFS_CTRL_TWO, 8'h42);
      host_u.wr(OFS_CTRL_FOUR, {5'h00, MODE_CONT_TO_STOP});
      for (int i = 0; i < 16; i++) push(1'b0, dat(i));
      det = 5'h01;
      push(1'b0, dat(16));
      chk(srdy, 1'b0);
      cnt(8'h08);
      det = 5'h00;
      for (int i = 0; i < 8; i++) begin
         host_u.read_word(t, p);
         chk({t, p}, {(i == 7) ? TAG_ACC_RAW : TAG_ACC_COMP, dat(i + 8)});
      end
      // rate change logged only while logging is enabled
      host_u.wr(OFS_CTRL_TWO, 8'h10);
      accr = 4'h5;
      repeat (3) @(negedge clk);
      cnt(8'h01);
      host_u.read_word(t, p);
      chk({t, p[47:40]}, {TAG_CFG_CHANGE, 8'h50});
      host_u.wr(OFS_CTRL_TWO, 8'h00);
      gyrr = 4'h3;
      repeat (3) @(negedge clk);
      cnt(8'h00);
      finish_test();
   end
endmodule : sensor_fifo_trigger_readout_test
